// *** hdl/rsf_top.sv ***
// rsf_top: return stack pointer, stack fault flags and fast save shadow.
// assumes the core sequencer drives one-cycle strobes on sys_clk_in;
// srst_in is the power-on reset; an apb master reaches the registers.
//
// How it works
// (RULE1) pointer five bits, upper three read zero
// (RULE2) enabled fault: set flag, then reset
// (RULE3) disabled fault: set flag only, no reset
// (RULE4) flags survive fault reset, cleared by software
// (RULE5) separate hidden one-entry shadow per register
// (RULE6) every interrupt vectoring saves all three
// (RULE7) fast interrupt return restores, otherwise untouched
// (RULE8) high priority vectoring overwrites low priority save
// (RULE9) fast call saves all three registers
// (RULE10) fast return restores all three registers
`timescale 1ns/1ns
module rsf_top (
    input  wire logic                     sys_clk_in,
    input  wire logic                     srst_in,
    // apb slave
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [7:0]               paddr_in,
    input  wire logic [31:0]              pwdata_in,
    output logic                          pready_out,
    output logic [31:0]                   prdata_out,
    output logic                          pslverr_out,
    // core sequencer strobes
    input  wire logic                     vector_in,
    input  wire logic                     sub_call_in,
    input  wire logic                     sub_return_in,
    input  wire logic                     interrupt_return_instruction_in,
    input  wire logic                     fast_opt_in,
    input  wire rsf_pkg::rsf_core_regs_s  core_regs_in,
    // results to the core
    output logic [4:0]                    stack_level_pointer_out,
    output logic                          restore_out,
    output rsf_pkg::rsf_core_regs_s       restore_regs_out,
    output logic                          fault_reset_out,
    output logic                          stack_full_flag_out,
    output logic                          stack_underflow_flag_out,
    output logic                          irq_out
);
    import rsf_pkg::*;

    rsf_top_state_s st_r;
    rsf_top_state_s st_nxt;

    logic                   push;
    logic                   pop;
    logic                   save;
    logic                   full_evt;
    logic                   unf_evt;
    logic                   wr_acc;
    logic                   rd_setup;
    logic                   addr_hit;
    logic [RSF_NFLAGS-1:0]  flags;
    logic [RSF_NFLAGS-1:0]  flag_set;
    logic [RSF_NFLAGS-1:0]  flag_clr;
    logic [31:0]            rd_word;

    // return address pushes and pops implied by the core's strobes
    assign push = vector_in | sub_call_in;
    assign pop  = sub_return_in | interrupt_return_instruction_in;

    // a vectoring saves whatever its priority, so a nested high priority
    // entry overwrites the low priority save; software must cover that
    assign save = vector_in | (sub_call_in & fast_opt_in); // (RULE6) (RULE8) (RULE9)

    // fault events: push onto a full stack, pop from an empty one
    assign full_evt = push & ~pop & (st_r.ptr == RSF_PTR_MAX);
    assign unf_evt  = pop & ~push & (st_r.ptr == RSF_PTR_MIN);

    // apb phase decode; zero wait states, so every access phase ends at once
    assign wr_acc   = psel_in & penable_in & pwrite_in;
    assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
    assign addr_hit = (paddr_in == RSF_OFF_PTR) | (paddr_in == RSF_OFF_CFG) |
                      (paddr_in == RSF_OFF_STAT) | (paddr_in == RSF_OFF_MASK);

    // flag set and write-one-to-clear strobes
    always_comb begin
        flag_set               = '0;
        flag_set[RSF_BIT_FULL] = full_evt; // (RULE2) (RULE3)
        flag_set[RSF_BIT_UNF]  = unf_evt;  // (RULE2) (RULE3)
        flag_clr               = '0;
        if (wr_acc && paddr_in == RSF_OFF_STAT) begin
            flag_clr = pwdata_in[RSF_NFLAGS-1:0]; // (RULE4)
        end
    end

    // sticky flags: only srst_in and software clear them, never fault_rst
    rsf_sticky u_full_flag (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .set_in     (flag_set[RSF_BIT_FULL]),
        .clr_in     (flag_clr[RSF_BIT_FULL]),
        .flag_out   (flags[RSF_BIT_FULL])
    ); // (RULE4)

    rsf_sticky u_unf_flag (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .set_in     (flag_set[RSF_BIT_UNF]),
        .clr_in     (flag_clr[RSF_BIT_UNF]),
        .flag_out   (flags[RSF_BIT_UNF])
    ); // (RULE4)

    // one hidden shadow per core register, no bus path to any of them
    rsf_shadow #(
        .W (8)
    ) u_shd_status (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .save_in    (save),
        .value_in   (core_regs_in.status),
        .value_out  (restore_regs_out.status)
    ); // (RULE5)

    rsf_shadow #(
        .W (8)
    ) u_shd_accum (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .save_in    (save),
        .value_in   (core_regs_in.accum),
        .value_out  (restore_regs_out.accum)
    ); // (RULE5)

    rsf_shadow #(
        .W (8)
    ) u_shd_bank (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .save_in    (save),
        .value_in   (core_regs_in.bank_sel),
        .value_out  (restore_regs_out.bank_sel)
    ); // (RULE5)

    // restore only on a return that carries the fast option
    assign restore_out = (interrupt_return_instruction_in | sub_return_in) &
                         fast_opt_in; // (RULE7) (RULE10)

    // read mux; unmapped offsets and reserved bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr_in)
            RSF_OFF_PTR: begin
                rd_word[RSF_PTR_W-1:0] = st_r.ptr; // (RULE1)
            end
            RSF_OFF_CFG: begin
                rd_word[RSF_BIT_FRE] = st_r.fault_en;
            end
            RSF_OFF_STAT: begin
                rd_word[RSF_NFLAGS-1:0] = flags;
            end
            RSF_OFF_MASK: begin
                rd_word[RSF_NFLAGS-1:0] = st_r.mask;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // next state: core stack moves, software writes, then fault reset
    always_comb begin
        st_nxt           = st_r;
        st_nxt.fault_rst = 1'b0;

        // pointer saturates; a fault leaves it where it was
        if (push && !pop && st_r.ptr != RSF_PTR_MAX) begin
            st_nxt.ptr = st_r.ptr + 5'h01;
        end else if (pop && !push && st_r.ptr != RSF_PTR_MIN) begin
            st_nxt.ptr = st_r.ptr - 5'h01;
        end

        // reset request rises with the flag, one cycle after the event;
        // its effect on the pointer lands a cycle later still
        if (st_r.fault_en && (full_evt || unf_evt)) begin
            st_nxt.fault_rst = 1'b1; // (RULE2)
        end else begin
            st_nxt.fault_rst = 1'b0; // (RULE3)
        end

        // software write takes effect at the access edge
        if (wr_acc) begin
            case (paddr_in)
                RSF_OFF_PTR: begin
                    st_nxt.ptr = pwdata_in[RSF_PTR_W-1:0]; // (RULE1)
                end
                RSF_OFF_CFG: begin
                    st_nxt.fault_en = pwdata_in[RSF_BIT_FRE];
                end
                RSF_OFF_MASK: begin
                    st_nxt.mask = pwdata_in[RSF_NFLAGS-1:0];
                end
                default: begin
                    st_nxt.mask = st_r.mask;
                end
            endcase
        end

        // the device reset empties the return stack but keeps the flags
        if (st_r.fault_rst) begin
            st_nxt.ptr = RSF_PTR_RST; // (RULE4)
        end

        // read data captured in setup so it is a flop in the access phase
        if (rd_setup) begin
            st_nxt.rdata = rd_word;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_r <= RSF_TOP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // bus answers: always ready, error on an unmapped offset
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~addr_hit;
    assign prdata_out  = st_r.rdata;

    // outputs to the core and the interrupt controller
    assign stack_level_pointer_out  = st_r.ptr;
    assign fault_reset_out          = st_r.fault_rst;
    assign stack_full_flag_out      = flags[RSF_BIT_FULL];
    assign stack_underflow_flag_out = flags[RSF_BIT_UNF];
    assign irq_out                  = |(flags & st_r.mask);
endmodule

// *** hdl/rsf_pkg.sv ***
// rsf_pkg: constants, register map and carrier types of the return stack
// fault and fast save block.
// assumes one core clock domain; every file imports this package whole.
package rsf_pkg;

    // stack pointer geometry
    localparam int         RSF_PTR_W   = 5;
    localparam logic [4:0] RSF_PTR_MAX = 5'h1f;
    localparam logic [4:0] RSF_PTR_MIN = 5'h00;
    localparam logic [4:0] RSF_PTR_RST = 5'h00;

    // apb geometry
    localparam int RSF_ADDR_W = 8;
    localparam int RSF_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] RSF_OFF_PTR  = 8'h00;
    localparam logic [7:0] RSF_OFF_CFG  = 8'h04;
    localparam logic [7:0] RSF_OFF_STAT = 8'h08;
    localparam logic [7:0] RSF_OFF_MASK = 8'h0c;

    // field positions
    localparam int RSF_BIT_FULL = 0;
    localparam int RSF_BIT_UNF  = 1;
    localparam int RSF_BIT_FRE  = 0;
    localparam int RSF_NFLAGS   = 2;

    // values after reset
    localparam logic       RSF_CFG_RST  = 1'b0;
    localparam logic [1:0] RSF_MASK_RST = 2'b00;
    localparam logic       RSF_FLAG_RST = 1'b0;
    localparam logic [7:0] RSF_SHD_RST  = 8'h00;

    // core register values that are saved and restored together
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] accum;
        logic [7:0] bank_sel;
    } rsf_core_regs_s;

    // whole state of the top module
    typedef struct packed {
        logic [4:0]  ptr;
        logic        fault_en;
        logic [1:0]  mask;
        logic [31:0] rdata;
        logic        fault_rst;
    } rsf_top_state_s;

    localparam rsf_top_state_s RSF_TOP_RST = '{
        ptr:       RSF_PTR_RST,
        fault_en:  RSF_CFG_RST,
        mask:      RSF_MASK_RST,
        rdata:     32'h0000_0000,
        fault_rst: 1'b0
    };

endpackage

// *** hdl/rsf_shadow.sv ***
// rsf_shadow: one-entry shadow store for one core register.
// assumes save and restore strobes from the same clock; no bus access.
`timescale 1ns/1ns
module rsf_shadow #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_in,
    input  wire logic         srst_in,
    input  wire logic         save_in,
    input  wire logic [W-1:0] value_in,
    output logic      [W-1:0] value_out
);
    import rsf_pkg::*;

    typedef struct packed {
        logic [W-1:0] held;
    } rsf_shd_state_s;

    rsf_shd_state_s st_r;
    rsf_shd_state_s st_nxt;

    // a later save simply overwrites: one level deep only
    always_comb begin
        st_nxt = st_r;
        if (save_in) begin
            st_nxt.held = value_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_r <= '{held: W'(RSF_SHD_RST)};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_out = st_r.held;
endmodule

// *** hdl/rsf_sticky.sv ***
// rsf_sticky: sticky event flag, cleared by a write of one.
// assumes set and clear pulses from the same clock; only srst_in resets it.
`timescale 1ns/1ns
module rsf_sticky (
    input  wire logic sys_clk_in,
    input  wire logic srst_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_out
);
    import rsf_pkg::*;

    typedef struct packed {
        logic flag;
    } rsf_stk_state_s;

    rsf_stk_state_s st_r;
    rsf_stk_state_s st_nxt;

    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        st_nxt      = st_r;
        st_nxt.flag = set_in | (st_r.flag & ~clr_in);
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_r <= '{flag: RSF_FLAG_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_out = st_r.flag;
endmodule

// *** test/rsf_props.sv ***
// rsf_props: concurrent checks on the ports of rsf_top.
// assumes one core clock; srst_in disables every check.
`timescale 1ns/1ns
module rsf_props (
    input wire logic                    sys_clk_in,
    input wire logic                    srst_in,
    input wire logic                    vector_in,
    input wire logic                    sub_call_in,
    input wire logic                    sub_return_in,
    input wire logic                    interrupt_return_instruction_in,
    input wire logic                    fast_opt_in,
    input wire rsf_pkg::rsf_core_regs_s core_regs_in,
    input wire logic [4:0]              stack_level_pointer_out,
    input wire logic                    restore_out,
    input wire rsf_pkg::rsf_core_regs_s restore_regs_out,
    input wire logic                    fault_reset_out,
    input wire logic                    stack_full_flag_out,
    input wire logic                    stack_underflow_flag_out
);
    import rsf_pkg::*;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    // decoded strobe groups
    wire logic pop  = sub_return_in | interrupt_return_instruction_in;
    wire logic push = vector_in | sub_call_in;
    wire logic save = vector_in | (sub_call_in & fast_opt_in);
    // the flag shows first, the pointer is cleared a cycle later
    sequence flag_clr_seq;
        (stack_full_flag_out | stack_underflow_flag_out) ##1 (stack_level_pointer_out == 5'h00);
    endsequence
    rst_order_a: assert property (
        fault_reset_out |-> flag_clr_seq) else $error("fault reset without flag or clear");
    rst_once_a: assert property (
        fault_reset_out |=> !fault_reset_out) else $error("fault reset too long");
    flag_keep_a: assert property (
        fault_reset_out |=> $stable({stack_full_flag_out, stack_underflow_flag_out}))
        else $error("fault reset changed a flag");
    full_set_a: assert property (
        push && !pop && stack_level_pointer_out == 5'h1f |=> stack_full_flag_out)
        else $error("full flag not set");
    unf_set_a: assert property (
        pop && !push && stack_level_pointer_out == 5'h00 |=> stack_underflow_flag_out)
        else $error("underflow flag not set");
    save_ld_a: assert property (
        save |=> restore_regs_out == $past(core_regs_in)) else $error("shadow not saved");
    save_hold_a: assert property (
        !save |=> $stable(restore_regs_out)) else $error("shadow changed");
    restore_a: assert property (
        restore_out == (pop && fast_opt_in)) else $error("restore strobe wrong");
endmodule
bind rsf_top rsf_props i_rsf_props (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .vector_in(vector_in),
    .sub_call_in(sub_call_in), .sub_return_in(sub_return_in),
    .interrupt_return_instruction_in(interrupt_return_instruction_in),
    .fast_opt_in(fast_opt_in), .core_regs_in(core_regs_in),
    .stack_level_pointer_out(stack_level_pointer_out), .restore_out(restore_out),
    .restore_regs_out(restore_regs_out), .fault_reset_out(fault_reset_out),
    .stack_full_flag_out(stack_full_flag_out),
    .stack_underflow_flag_out(stack_underflow_flag_out)
);

// *** test/rsf_core_model.sv ***
// rsf_core_model: core sequencer that issues stack strobes and keeps
// the live status, accumulator and bank select values.
// assumes op_in and load_in change just after a rising edge.
`timescale 1ns/1ns
module rsf_core_model (
    input  wire logic                    sys_clk_in,
    input  wire logic [2:0]              op_in,
    input  wire logic                    fast_in,
    input  wire logic                    load_in,
    input  wire rsf_pkg::rsf_core_regs_s val_in,
    input  wire logic                    restore_in,
    input  wire rsf_pkg::rsf_core_regs_s restore_regs_in,
    output logic                         vector_out,
    output logic                         call_out,
    output logic                         return_out,
    output logic                         iret_out,
    output logic                         fast_out,
    output rsf_pkg::rsf_core_regs_s      regs_out
);
    import rsf_pkg::*;
    // one strobe per cycle: 1 vector, 2 call, 3 return, 4 interrupt return
    assign vector_out = (op_in == 3'h1);
    assign call_out   = (op_in == 3'h2);
    assign return_out = (op_in == 3'h3);
    assign iret_out   = (op_in == 3'h4);
    assign fast_out   = fast_in;
    // a restore wins over a load, as the core takes back the saved set
    always @(posedge sys_clk_in) begin
        if (restore_in === 1'b1) begin
            regs_out <= restore_regs_in;
        end else if (load_in) begin
            regs_out <= val_in;
        end
    end
endmodule

// *** test/testbench.sv ***
// testbench: self-checking bench of rsf_top with a core model beside it.
// assumes rsf_pkg, rsf_top and rsf_core_model are compiled first.
`timescale 1ns/1ns
module testbench;
    import rsf_pkg::*;
    localparam logic [23:0] KA = 24'h1a2b3c, KB = 24'h445566, KC = 24'h778899;
    localparam logic [23:0] KD = 24'ha1b2c3, KE = 24'hd4e5f6;
    logic           clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic           pready, pslverr, vec, call, ret, iret, fo, rsto, frst, full, unf;
    logic           irq, fast = 1'b0, load = 1'b0, e;
    logic [2:0]     op = 3'h0;
    logic [4:0]     ptr;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0, prdata, q;
    rsf_core_regs_s val = '0, regs, rregs;
    int             bad_count = 0, num_checks = 0, cyc = 0, rst_cnt = 0;
    always #50 clk = ~clk;
    rsf_top i_rsf_top (.sys_clk_in(clk), .srst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
        .prdata_out(prdata), .pslverr_out(pslverr), .vector_in(vec), .sub_call_in(call),
        .sub_return_in(ret), .interrupt_return_instruction_in(iret), .fast_opt_in(fo),
        .core_regs_in(regs), .stack_level_pointer_out(ptr), .restore_out(rsto),
        .restore_regs_out(rregs), .fault_reset_out(frst), .stack_full_flag_out(full),
        .stack_underflow_flag_out(unf), .irq_out(irq));
    rsf_core_model i_rsf_core_model (.sys_clk_in(clk), .op_in(op), .fast_in(fast),
        .load_in(load), .val_in(val), .restore_in(rsto), .restore_regs_in(rregs),
        .vector_out(vec), .call_out(call), .return_out(ret), .iret_out(iret),
        .fast_out(fo), .regs_out(regs));
    // hang guard and fault reset pulse count
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (frst === 1'b1) rst_cnt <= rst_cnt + 1;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
        chk(32'(e), 32'(a > RSF_OFF_MASK));
    endtask
    // core values loaded first, then one strobe cycle
    task core(input logic [2:0] o, input logic f, input logic [23:0] v);
        @(posedge clk);
        load <= 1'b1;
        val <= v;
        @(posedge clk);
        load <= 1'b0;
        op <= o;
        fast <= f;
        @(posedge clk);
        op <= 3'h0;
        fast <= 1'b0;
        // the model's register update lands at this edge; look at it mid-cycle
        @(negedge clk);
    endtask
    task t_regs;
        rdc(RSF_OFF_PTR, 32'h0);
        rdc(RSF_OFF_STAT, 32'h0);
        rdc(RSF_OFF_MASK, 32'h0);
        apb(1'b1, RSF_OFF_PTR, 32'hffff_ffff);
        rdc(RSF_OFF_PTR, 32'h1f);
        rdc(8'h10, 32'h0);
    endtask
    task t_off;
        core(3'h1, 1'b0, KA);
        rdc(RSF_OFF_PTR, 32'h1f);
        apb(1'b1, RSF_OFF_PTR, 32'h0);
        core(3'h3, 1'b0, KA);
        rdc(RSF_OFF_STAT, 32'h3);
        chk(rst_cnt, 0);
    endtask
    task t_irq;
        @(negedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, RSF_OFF_MASK, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, RSF_OFF_STAT, 32'h2);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        rdc(RSF_OFF_STAT, 32'h1);
        apb(1'b1, RSF_OFF_STAT, 32'h1);
    endtask
    task t_on;
        apb(1'b1, RSF_OFF_CFG, 32'h1);
        rdc(RSF_OFF_CFG, 32'h1);
        apb(1'b1, RSF_OFF_PTR, 32'h1f);
        core(3'h2, 1'b0, KA);
        rdc(RSF_OFF_STAT, 32'h1);
        chk(rst_cnt, 1);
        rdc(RSF_OFF_PTR, 32'h0);
        core(3'h3, 1'b0, KA);
        rdc(RSF_OFF_STAT, 32'h3);
        chk(rst_cnt, 2);
        apb(1'b1, RSF_OFF_CFG, 32'h0);
        apb(1'b1, RSF_OFF_STAT, 32'h3);
    endtask
    task t_shadow;
        core(3'h1, 1'b0, KA);
        core(3'h2, 1'b0, KB);
        core(3'h4, 1'b1, KB);
        chk(32'(regs), 32'(KA));
        core(3'h1, 1'b0, KB);
        core(3'h1, 1'b0, KC);
        core(3'h4, 1'b1, KA);
        chk(32'(regs), 32'(KC));
        core(3'h2, 1'b1, KD);
        core(3'h3, 1'b1, KA);
        chk(32'(regs), 32'(KD));
        core(3'h3, 1'b0, KE);
        chk(32'(regs), 32'(KE));
        core(3'h4, 1'b0, KB);
        chk(32'(regs), 32'(KB));
        rdc(RSF_OFF_PTR, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_off();
        t_irq();
        t_on();
        t_shadow();
        summarize();
    end
endmodule
